// [inc/rev_info_map.vh]
// Command codes, field positions and limits of the reverse limit and information registers
`ifndef REV_INFO_MAP_VH
`define REV_INFO_MAP_VH

// Command codes
`define CMD_INFO_STATUS      8'h3A
`define CMD_REV_CUR_LIMIT    8'h4A

// Reverse current limit field
`define RCL_LSB              7
`define RCL_MSB              12
`define RCL_WIDTH            6
`define RCL_MAX_CODE         6'h20
`define RCL_RESET_CODE       6'h00
`define RCL_STEP_MA          128

// Information fields
`define INF_STRAP_LSB        0
`define INF_TRICKLE_BIT      4
`define INF_MODE_LSB         5
`define INF_STATE_LSB        7
`define INF_LOW_RAIL_BIT     10
`define INF_DISCH_BIT        11
`define INF_ADP_BIT          12
`define INF_LOOP_LSB         13
`define INF_REF_BIT          15

// Reset values and zero padding of the limit word
`define STRAP_RESET          4'h0
`define WORD_ZERO            16'h0000
`define MA_ZERO              13'h0000
`define RCL_PAD_LO           7'h00
`define RCL_PAD_HI           3'h0

`endif

// [src/rcl_clamp.v]
// Keeps the valid bits of a written current word and clamps them to the maximum code
`timescale 1ns/1ps
`default_nettype none
`include "rev_info_map.vh"

module rcl_clamp (
	// Written word
	input  wire [15:0]           wr_word_i,
	// Stored field, clamped
	output wire [`RCL_WIDTH-1:0] field_o
);
	wire [`RCL_WIDTH-1:0] raw;

	// Only bits 12..7 survive; others are dropped
	assign raw     = wr_word_i[`RCL_MSB:`RCL_LSB]; // RULE2
	// Any code above the top step is held at the top step
	assign field_o = (raw > `RCL_MAX_CODE) ? `RCL_MAX_CODE : raw; // RULE3
endmodule // rcl_clamp
`default_nettype wire

// [src/info_pack.v]
// Packs live status fields into the 16-bit information word
`timescale 1ns/1ps
`default_nettype none
`include "rev_info_map.vh"

module info_pack (
	// Status fields
	input  wire [3:0]  strap_i,
	input  wire        trickle_i,
	input  wire [1:0]  mode_i,
	input  wire [2:0]  state_i,
	input  wire        low_rail_i,
	input  wire        discharge_i,
	input  wire        adapter_i,
	input  wire [1:0]  loop_i,
	input  wire        ref_i,
	// Packed word
	output wire [15:0] word_o
);
	// Field order from bit 15 downward
	assign word_o = {ref_i, loop_i, adapter_i, discharge_i, low_rail_i,
		state_i, mode_i, trickle_i, strap_i};
endmodule // info_pack
`default_nettype wire

// [src/rev_info_regs.v]
// Reverse current limit register and read-only information register
// What this block does
// RULE1 - Write-word at command 0x4A updates the reverse current limit register.
// RULE2 - Only bits 12..7 of the written word are stored; rest discarded.
// RULE3 - Stored limit is clamped so it never exceeds the 4096mA code.
// RULE4 - Limit bits 7..12 weigh 128 to 4096 mA; milliamp value is reported.
// RULE5 - A 16-bit read-only information register answers at command 0x3A.
// RULE6 - Bits 3..0 report the strap-resistor configuration code.
// RULE7 - Battery-only: strap code shown only after sampling with power monitor enabled.
// RULE8 - Bit 4 is high while trickle charging is active.
// RULE9 - Bits 6..5 report power-stage mode: step-down, step-up, both, reverse.
// RULE10 - Bits 9..7 report the state-machine state code.
// RULE11 - Bit 10 reports the low system-rail throttle trip.
// RULE12 - Bit 11 reports the battery-discharge throttle trip.
// RULE13 - Bit 12 reports the adapter-current throttle trip.
// RULE14 - Bits 14..13 report the active regulation loop.
// RULE15 - Bit 15 is high while the internal reference is active.
// RULE16 - Writes to the information command change no reported field.
`timescale 1ns/1ps
`default_nettype none
`include "rev_info_map.vh"

module rev_info_regs (
	// Clock and reset
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	// Register access from the serial bus engine
	input  wire        wr_stb_i,
	input  wire        rd_stb_i,
	input  wire [7:0]  cmd_i,
	input  wire [15:0] wr_data_i,
	output reg  [15:0] rd_data_o,
	output reg         rd_hit_o,
	// Live status from the charger core
	input  wire [3:0]  config_strap_pin_i,
	input  wire        battery_only_i,
	input  wire        system_power_monitor_en_i,
	input  wire        trickle_active_i,
	input  wire [1:0]  stage_mode_i,
	input  wire [2:0]  charger_state_i,
	input  wire        low_rail_throttle_i,
	input  wire        discharge_throttle_i,
	input  wire        adapter_current_throttle_i,
	input  wire [1:0]  active_loop_i,
	input  wire        reference_active_i,
	// Reverse current limit toward the power stage
	output reg  [15:0] reverse_current_limit_o,
	output reg  [12:0] reverse_limit_ma_o
);
	reg  [`RCL_WIDTH-1:0] rcl_ff;
	reg  [3:0]            strap_ff;
	reg                   strap_valid_ff;
	reg  [3:0]            nxt_strap;
	reg                   nxt_strap_valid;
	wire [`RCL_WIDTH-1:0] rcl_clamped;
	wire [15:0]           info_word;
	wire [3:0]            strap_shown;

	// Milliamp weight of a limit code, 128 mA per step
	function [12:0] code_to_ma;
		input [`RCL_WIDTH-1:0] code;
		begin
			code_to_ma = {code, `RCL_PAD_LO}; // RULE4
		end
	endfunction

	// Field filter and clamp for incoming limit words
	rcl_clamp u_clamp (
		.wr_word_i (wr_data_i),
		.field_o   (rcl_clamped)
	);

	// Limit register; only its own command code updates it
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rcl_ff <= `RCL_RESET_CODE;
		end else if (wr_stb_i && cmd_i == `CMD_REV_CUR_LIMIT) begin // RULE1
			rcl_ff <= rcl_clamped; // RULE2 RULE3
		end
	end

	// Strap capture: with an adapter the code is valid at once; on battery
	// alone it waits for the power monitor, since the strap is read then
	always @* begin
		nxt_strap       = strap_ff;
		nxt_strap_valid = strap_valid_ff;
		if (!battery_only_i || system_power_monitor_en_i) begin // RULE7
			nxt_strap       = config_strap_pin_i;
			nxt_strap_valid = 1'b1;
		end
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			strap_ff       <= `STRAP_RESET;
			strap_valid_ff <= 1'b0;
		end else begin
			strap_ff       <= nxt_strap;
			strap_valid_ff <= nxt_strap_valid;
		end
	end

	// Unsampled strap reads as zero, not stale pin state
	assign strap_shown = strap_valid_ff ? strap_ff : `STRAP_RESET; // RULE6 RULE7

	// Status word built from live inputs and the registered strap code; no write path exists into it
	info_pack u_pack (
		.strap_i     (strap_shown),
		.trickle_i   (trickle_active_i), // RULE8
		.mode_i      (stage_mode_i), // RULE9
		.state_i     (charger_state_i), // RULE10
		.low_rail_i  (low_rail_throttle_i), // RULE11
		.discharge_i (discharge_throttle_i), // RULE12
		.adapter_i   (adapter_current_throttle_i), // RULE13
		.loop_i      (active_loop_i), // RULE14
		.ref_i       (reference_active_i), // RULE15
		.word_o      (info_word)
	);

	// Read mux and registered outputs; unknown commands read zero with no hit
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rd_data_o               <= `WORD_ZERO;
			rd_hit_o                <= 1'b0;
			reverse_current_limit_o <= `WORD_ZERO;
			reverse_limit_ma_o      <= `MA_ZERO;
		end else begin
			reverse_current_limit_o <= {`RCL_PAD_HI, rcl_ff, `RCL_PAD_LO};
			reverse_limit_ma_o      <= code_to_ma(rcl_ff); // RULE4
			rd_hit_o                <= 1'b0;
			if (rd_stb_i) begin
				case (cmd_i)
					`CMD_INFO_STATUS: begin
						rd_data_o <= info_word; // RULE5 RULE16
						rd_hit_o  <= 1'b1;
					end
					`CMD_REV_CUR_LIMIT: begin
						rd_data_o <= {`RCL_PAD_HI, rcl_ff, `RCL_PAD_LO};
						rd_hit_o  <= 1'b1;
					end
					default: begin
						rd_data_o <= `WORD_ZERO;
					end
				endcase
			end
		end
	end
endmodule // rev_info_regs
`default_nettype wire

// [test/rev_info_asserts.sv]
// Port checks for the reverse limit and information registers
`timescale 1ns/1ps
`default_nettype none
module rev_info_asserts (
	input wire logic        core_clk_i, rst_n_i, wr_stb_i, rd_stb_i, rd_hit_o, reference_active_i,
	input wire logic [7:0]  cmd_i,
	input wire logic [15:0] wr_data_i, rd_data_o, reverse_current_limit_o,
	input wire logic [12:0] reverse_limit_ma_o,
	input wire logic [1:0]  stage_mode_i, active_loop_i,
	input wire logic [2:0]  charger_state_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Decoded requests and the live fields visible here
	wire        wl  = wr_stb_i && cmd_i == 8'h4A;
	wire        ri  = rd_stb_i && cmd_i == 8'h3A;
	wire [5:0]  wc  = wr_data_i[12:7];
	wire [7:0]  lv  = {reference_active_i, active_loop_i, charger_state_i, stage_mode_i};
	wire [15:0] lim = reverse_current_limit_o;
	AST_STORE: assert property (wl && wc <= 6'h20 |-> ##2 lim == {3'h0, $past(wc, 2), 7'h00})
		else $error("limit not stored");
	AST_CLAMP: assert property (wl && wc > 6'h20 |-> ##2 lim == 16'h1000)
		else $error("limit not clamped");
	AST_MA: assert property (reverse_limit_ma_o == lim[12:0])
		else $error("milliamp value wrong");
	AST_UNUSED: assert property (lim[15:13] == 3'h0 && lim[6:0] == 7'h00)
		else $error("unused limit bits set");
	AST_INFO: assert property (ri |=> rd_hit_o && {rd_data_o[15:13], rd_data_o[9:5]} == $past(lv))
		else $error("info word wrong");
	AST_OTHER: assert property (rd_stb_i && cmd_i != 8'h3A && cmd_i != 8'h4A |=>
		!rd_hit_o && rd_data_o == 16'h0000) else $error("unmapped read answered");
	AST_RO: assert property (wr_stb_i && cmd_i == 8'h3A && !$past(wr_stb_i) |=> $stable(lim))
		else $error("info write had effect");
	AST_HIT: assert property (rd_hit_o |-> $past(rd_stb_i))
		else $error("stray read answer");
	cover property (wl && wc > 6'h20);
	cover property (ri ##1 rd_hit_o);
	cover property (wr_stb_i && cmd_i == 8'h3A);
endmodule // rev_info_asserts
bind rev_info_regs rev_info_asserts i_rev_info_asserts (.*);
`default_nettype wire

// [test/smbus_host.sv]
// Host model issuing one register word transfer at a time
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
	input  wire logic        core_clk_i,
	output var  logic [25:0] req_o
);
	initial req_o = 26'h0000000;
	// Held over one rising edge, then released with both strobes cleared and command and data inverted so stale data never looks valid
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(negedge core_clk_i);
		req_o = {w, !w, c, d};
		@(negedge core_clk_i);
		req_o = {2'h0, ~c, ~d};
	endtask
endmodule // smbus_host
`default_nettype wire

// [test/rev_info_regs_tb.sv]
// Self-checking bench for the reverse limit and information registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t %h!=%h", $time, a, e); end end
module rev_info_regs_tb;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [17:0] st = 18'h00000;
	logic [15:0] d, e, q[$];
	logic [15:0] wv [5] = '{16'hFFFF, 16'h1080, 16'h1000, 16'h0F80, 16'hE07F};
	wire  [25:0] rq;
	wire  [15:0] rd_data_o;
	wire         rd_hit_o;
	wire  [15:0] lim;
	wire  [12:0] ma;
	int          n_fail = 0, checks = 0, cyc = 0;
	smbus_host i_smbus_host (.core_clk_i, .req_o(rq));
	rev_info_regs i_rev_info_regs (.core_clk_i, .rst_n_i, .wr_stb_i(rq[25]), .rd_stb_i(rq[24]),
		.cmd_i(rq[23:16]), .wr_data_i(rq[15:0]), .rd_data_o, .rd_hit_o,
		.config_strap_pin_i(st[3:0]), .battery_only_i(st[4]), .system_power_monitor_en_i(st[5]),
		.trickle_active_i(st[6]), .stage_mode_i(st[8:7]), .charger_state_i(st[11:9]),
		.low_rail_throttle_i(st[12]), .discharge_throttle_i(st[13]),
		.adapter_current_throttle_i(st[14]), .active_loop_i(st[16:15]),
		.reference_active_i(st[17]), .reverse_current_limit_o(lim), .reverse_limit_ma_o(ma));
	task automatic close_out;
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] x);
		q.push_back(x);
		i_smbus_host.xfer(1'b0, c, 16'h0000);
	endtask
	initial forever #4 core_clk_i = ~core_clk_i;
	// Answers are looked at mid-cycle, where they have settled
	always @(negedge core_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			close_out();
		end else if (rd_hit_o === 1'b1)
			`CHK(rd_data_o, q.size() ? q.pop_front() : ~rd_data_o)
	end
	initial begin
		void'($urandom(32'hCDEC8543));
		st = 18'($urandom) | 18'h00010;
		st[5] = 1'b0;
		repeat (6) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		rd(8'h3A, {st[17:6], 4'h0});
		// Status held a full cycle before each read, so the strap capture has settled
		for (int i = 0; i < 32; i++) begin
			st = 18'($urandom);
			st[16:7] = {i[1:0], st[14:12], i[4:0]};
			st[5:4] = 2'h2;
			if (i[0])
				i_smbus_host.xfer(1'b1, 8'h3A, 16'($urandom));
			rd(8'h3A, {st[17:6], st[3:0]});
		end
		for (int k = 0; k < 10; k++) begin
			d = k < 5 ? wv[k] : 16'($urandom);
			e = {3'h0, d[12:7] > 6'h20 ? 6'h20 : d[12:7], 7'h00};
			i_smbus_host.xfer(1'b1, 8'h4A, d);
			rd(8'h4A, e);
		end
		i_smbus_host.xfer(1'b1, 8'h4B, 16'h0F80);
		i_smbus_host.xfer(1'b0, 8'h49, 16'h0000);
		rd(8'h4A, e);
		repeat (2) @(negedge core_clk_i);
		`CHK(q.size(), 0)
		`CHK(lim, e)
		`CHK(ma, e[12:0])
		close_out();
	end
endmodule // rev_info_regs_tb
`default_nettype wire
